// file: include/pmt_cfg.svh
/*
 pmt_cfg.svh: constants of the bus target port (addresses, command codes,
 reset values, timing counts). Assumes a 125 MHz reference clock.
*/
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

// address space
`define PMT_ADDR_LO_BASE     7'h40
`define PMT_ADDR_HI_BASE     7'h50
`define PMT_ADDR_LO_COUNT    5'h08
`define PMT_ARA_ADDR7        7'h0C
`define PMT_RW_READ          1'b1

// command codes
`define PMT_CMD_PAGE         8'h00
`define PMT_CMD_CLEAR_FAULTS 8'h03

// page values and reset
`define PMT_PAGE_RAIL0       8'h00
`define PMT_PAGE_RAIL1       8'h01
`define PMT_PAGE_BOTH        8'hFF
`define PMT_PAGE_RESET       8'h00
`define PMT_IDLE_BYTE        8'hFF

// timing: 8 ns clock, 100 ns data hold, 2 MHz and 50 kHz bus clock
`define PMT_CLK_PERIOD_PS    32'h0000_1F40
`define PMT_SDA_HOLD_PS      32'h0001_86A0
`define PMT_SCL_MAX_PER_PS   32'h0007_A120
`define PMT_SCL_MIN_PER_PS   32'h0131_2D00
`define PMT_SDA_HOLD_CYC \
   ((`PMT_SDA_HOLD_PS + `PMT_CLK_PERIOD_PS - 1) / `PMT_CLK_PERIOD_PS)
`define PMT_SCL_HALF_CYC \
   ((`PMT_SCL_MAX_PER_PS / 2) / `PMT_CLK_PERIOD_PS)
`define PMT_SYNC_LAT_CYC     4

`endif

// file: include/pmt_line_if.sv
/*
 pmt_line_if: conditioned bus line events passed from the line
 conditioner to the protocol engine. All signals on the reference clock.
*/
`timescale 1ns/1ps
interface pmt_line_if;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic sda;
   modport src (output rise, output fall, output start, output stop,
                output sda);
   modport dst (input rise, input fall, input start, input stop,
                input sda);
endinterface

// file: include/pmt_pkg.sv
/*
 pmt_pkg: types of the bus target port: engine states and the state
 records of the line conditioner and of the protocol engine.
*/
package pmt_pkg;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0000,
      ST_ADDR     = 4'b0001,
      ST_ADDR_ACK = 4'b0010,
      ST_CMD      = 4'b0011,
      ST_CMD_ACK  = 4'b0100,
      ST_WDATA    = 4'b0101,
      ST_WACK     = 4'b0110,
      ST_RDATA    = 4'b0111,
      ST_MACK     = 4'b1000,
      ST_RLOAD    = 4'b1001,
      ST_IGNORE   = 4'b1010
   } pmt_state_t;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
      logic [1:0] filt;
      logic       rise;
      logic       fall;
      logic       start;
      logic       stop;
   } pmt_sync_t;

   typedef struct packed {
      pmt_state_t st;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic [7:0] cmd;
      logic       cmd_ok;
      logic [7:0] idx;
      logic [7:0] page;
      logic [1:0] rail;
      logic       alert;
      logic       rw;
      logic       ara;
      logic       oe;
      logic       pend;
      logic [7:0] hold;
      logic [6:0] addr7;
      logic       addr_ok;
      logic       cmd_stb;
      logic       wr_stb;
      logic       clr;
   } pmt_core_t;

endpackage

// file: sim/pmt_host_model.sv
/*
 pmt_host_model: bus host on the far side of the target port.
 assumes one task at a time from the bench; pull-up on the data line.
*/
`timescale 1ns/1ps
module pmt_host_model #(
   parameter int H = 32
) (
   // clock
   input  wire logic ref_clk,
   // target drive
   input  wire logic sda_oe,
   // resolved lines
   output wire logic scl,
   output wire logic sda
);
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   // released line floats up, so a low from either side wins
   assign scl = scl_q;
   assign sda = sda_q & ~sda_oe;

   task automatic wt(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // half period of 32 cycles, just under 2 MHz
   // data moves only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      wt(4);
      sda_q = b;
      wt(H - 4);
      scl_q = 1'b1;
      wt(H / 2);
      r = sda;
      wt(H / 2);
      scl_q = 1'b0;
   endtask

   // msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] tx, input logic ab,
                       output logic [7:0] rx, output logic ak);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ab, ak);
   endtask

   // repeated start uses the same path, no stop before it
   task automatic start;
      wt(4);
      sda_q = 1'b1;
      wt(H - 4);
      scl_q = 1'b1;
      wt(H);
      sda_q = 1'b0;
      wt(H);
      scl_q = 1'b0;
   endtask

   task automatic stop;
      wt(4);
      sda_q = 1'b0;
      wt(H - 4);
      scl_q = 1'b1;
      wt(H);
      sda_q = 1'b1;
      wt(H);
   endtask
endmodule

// file: sim/pmt_target_port_chk.sv
/*
 pmt_target_port_chk: assertions on the target port pins.
 assumes binding to pmt_target_port on its reference clock.
*/
`timescale 1ns/1ps
module pmt_target_port_chk (
   // clock and reset
   input wire logic       REF_CLK,
   input wire logic       NRST,
   // pins
   input wire logic       SDA_OE,
   input wire logic       ALERT_OE,
   input wire logic [4:0] STRAP_CODE,
   input wire logic       FAULT_EVENT,
   // command side
   input wire logic       CLEAR_FAULTS,
   input wire logic [7:0] CMD_CODE,
   input wire logic       CMD_STROBE,
   // status
   input wire logic [7:0] PAGE,
   input wire logic [1:0] RAIL_SEL,
   input wire logic [6:0] OWN_ADDR,
   input wire logic       ADDR_READY,
   input wire logic       BUSY
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);

   sequence s_cmd_quiet;
      !CMD_STROBE [*8];
   endsequence

   function automatic logic [6:0] f_map(input logic [4:0] c);
      return (c < 5'h08) ? 7'h40 + {2'b00, c} : 7'h48 + {2'b00, c};
   endfunction

   a_page_rail_map:
      assert property (((PAGE == 8'h00) && (RAIL_SEL == 2'b01)) ||
                       ((PAGE == 8'h01) && (RAIL_SEL == 2'b10)) ||
                       ((PAGE == 8'hFF) && (RAIL_SEL == 2'b11)))
      else $error("page and rail disagree");
   a_strap_addr:
      assert property ($rose(ADDR_READY) |->
                       OWN_ADDR == f_map($past(STRAP_CODE)))
      else $error("address not from strap");
   a_addr_range:
      assert property (ADDR_READY |->
                       (OWN_ADDR inside {[7'h40:7'h47], [7'h50:7'h67]}))
      else $error("address out of range");
   a_cmd_quiet:
      assert property (CMD_STROBE |=> s_cmd_quiet)
      else $error("command strobe repeats");
   a_fault_alert:
      assert property (FAULT_EVENT |=> ALERT_OE)
      else $error("alert not raised");
   a_clear_cmd:
      assert property (CLEAR_FAULTS |-> CMD_CODE == 8'h03)
      else $error("clear without its command");
   a_clear_alert:
      assert property (CLEAR_FAULTS && !$past(FAULT_EVENT) |-> !ALERT_OE)
      else $error("alert kept after clear");
   a_idle_free:
      assert property (!BUSY && !$past(BUSY) |-> !SDA_OE)
      else $error("data driven while idle");
   a_drive_busy:
      assert property ($rose(SDA_OE) |-> BUSY)
      else $error("data driven outside a frame");
endmodule

bind pmt_target_port pmt_target_port_chk u_chk (
   .REF_CLK(REF_CLK), .NRST(NRST), .SDA_OE(SDA_OE), .ALERT_OE(ALERT_OE),
   .STRAP_CODE(STRAP_CODE), .FAULT_EVENT(FAULT_EVENT),
   .CLEAR_FAULTS(CLEAR_FAULTS), .CMD_CODE(CMD_CODE),
   .CMD_STROBE(CMD_STROBE), .PAGE(PAGE), .RAIL_SEL(RAIL_SEL),
   .OWN_ADDR(OWN_ADDR), .ADDR_READY(ADDR_READY), .BUSY(BUSY));

// file: sim/test_pmbus_target_port.sv
/*
 test_pmbus_target_port: self-checking bench of the target port.
 assumes the host model and the checker; back end read data is modelled.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   n_mismatch++; $display("MISMATCH %s exp %h seen %h", n, e, g); end end
module test_pmbus_target_port;
   localparam int LIMIT = 60000;
   logic       ref_clk, nrst, ce, strap_valid, smbus_mode, fault_event;
   logic [4:0] strap_code;
   wire        scl, sda;
   wire  [7:0] rd_data;
   logic       sda_oe, alert_oe, clear_faults, cmd_strobe, wr_strobe;
   logic       addr_ready, rd_req, sda_o, alert_o;
   logic [7:0] cmd_code, wr_data, rd_index, page, cmd_seen, wr_seen;
   logic [7:0] wr_index, widx_seen;
   logic [1:0] rail_sel;
   logic [6:0] own_addr, own7;
   int         n_mismatch = 0, samples_checked = 0, cyc = 0, clr_cnt = 0;
   int         oe_cnt = 0, rd_cnt = 0;

   // back end answers with the rail and the byte index
   assign rd_data = {rail_sel, 2'b00, rd_index[3:0]};

   pmt_target_port DUT (
      .REF_CLK(ref_clk), .NRST(nrst), .CE(ce), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .ALERT_O(alert_o), .ALERT_OE(alert_oe),
      .STRAP_CODE(strap_code), .STRAP_VALID(strap_valid),
      .SMBUS_MODE(smbus_mode), .FAULT_EVENT(fault_event),
      .CLEAR_FAULTS(clear_faults), .CMD_CODE(cmd_code),
      .CMD_STROBE(cmd_strobe), .WR_DATA(wr_data), .WR_STROBE(wr_strobe),
      .WR_INDEX(wr_index), .RD_REQ(rd_req), .RD_INDEX(rd_index),
      .RD_DATA(rd_data),
      .PAGE(page), .RAIL_SEL(rail_sel), .OWN_ADDR(own_addr),
      .ADDR_READY(addr_ready), .BUSY());
   pmt_host_model host (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl),
                        .sda(sda));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cmd_strobe === 1'b1) cmd_seen <= cmd_code;
      if (wr_strobe === 1'b1) wr_seen <= wr_data;
      if (wr_strobe === 1'b1) widx_seen <= wr_index;
      if (rd_req === 1'b1) rd_cnt <= rd_cnt + 1;
      if (clear_faults === 1'b1) clr_cnt <= clr_cnt + 1;
      if (sda_oe === 1'b1) oe_cnt <= oe_cnt + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic complete_run;
      $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic rst(input logic [4:0] c);
      nrst = 1'b0;
      strap_code = c;
      repeat (3) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (8) @(negedge ref_clk);
   endtask

   task automatic send(input logic [6:0] a, input logic [7:0] c,
                       input logic dn, input logic [7:0] d, output logic ak);
      logic [7:0] rx;
      logic       k;
      host.start();
      host.xfer({a, 1'b0}, 1'b1, rx, ak);
      host.xfer(c, 1'b1, rx, k);
      if (dn) host.xfer(d, 1'b1, rx, k);
      host.stop();
   endtask

   // brk puts a stop between the command and the read
   task automatic rd2(input logic [7:0] c, input logic brk,
                      output logic [15:0] v);
      logic [7:0] rx;
      logic       k;
      host.start();
      host.xfer({own7, 1'b0}, 1'b1, rx, k);
      host.xfer(c, 1'b1, rx, k);
      if (brk) host.stop();
      host.start();
      host.xfer({own7, 1'b1}, 1'b1, rx, k);
      host.xfer(8'hFF, 1'b0, v[7:0], k);
      host.xfer(8'hFF, 1'b1, v[15:8], k);
      host.stop();
   endtask

   task automatic pulse_fault;
      fault_event = 1'b1;
      @(negedge ref_clk);
      fault_event = 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic t_strap;
      logic [4:0] cd [4] = '{5'h00, 5'h07, 5'h1F, 5'h09};
      logic [6:0] ex [4] = '{7'h40, 7'h47, 7'h67, 7'h51};
      logic       ak;
      for (int i = 0; i < 4; i++) begin
         rst(cd[i]);
         own7 = ex[i];
         `CHK("own_addr", ex[i], own_addr)
         `CHK("page_reset", 8'h00, page)
         send(ex[i], 8'hFF - 8'(i), 1'b0, 8'h00, ak);
         `CHK("own_ack", 1'b0, ak)
         `CHK("cmd_code", 8'hFF - 8'(i), cmd_seen)
      end
      $display("strap test done");
   endtask

   task automatic t_foreign;
      logic ak;
      int   n;
      n = oe_cnt;
      send(7'h52, 8'h21, 1'b1, 8'h55, ak);
      `CHK("foreign_ack", 1'b1, ak)
      `CHK("foreign_drive", n, oe_cnt)
      `CHK("drive_level", 2'b00, {sda_o, alert_o})
      $display("foreign test done");
   endtask

   task automatic t_page;
      logic [7:0] dv [4] = '{8'h01, 8'hFF, 8'h05, 8'h00};
      logic [7:0] pv [4] = '{8'h01, 8'hFF, 8'hFF, 8'h00};
      logic [1:0] rv [4] = '{2'b10, 2'b11, 2'b11, 2'b01};
      logic       ak;
      for (int i = 0; i < 4; i++) begin
         send(own7, 8'h00, 1'b1, dv[i], ak);
         `CHK("page", pv[i], page)
         `CHK("rail_sel", rv[i], rail_sel)
         `CHK("wr_data", dv[i], wr_seen)
         `CHK("wr_index", 8'h00, widx_seen)
      end
      $display("page test done");
   endtask

   task automatic t_read;
      logic [15:0] v;
      logic [7:0]  b;
      logic        ak;
      int          n;
      for (int p = 0; p < 2; p++) begin
         send(own7, 8'h00, 1'b1, 8'(p), ak);
         n = rd_cnt;
         rd2(8'h8B, 1'b0, v);
         b = p ? 8'h80 : 8'h40;
         `CHK("read_rail", {b + 8'h01, b}, v)
         `CHK("read_reqs", n + 2, rd_cnt)
      end
      n = rd_cnt;
      rd2(8'h8B, 1'b1, v);
      `CHK("read_after_stop", 16'hFFFF, v)
      `CHK("stop_reqs", n, rd_cnt)
      // page is 1 here, so a mid-run reset must bring it back
      rst(5'h09);
      `CHK("page_rst", 8'h00, page)
      `CHK("rail_rst", 2'b01, rail_sel)
      $display("read test done");
   endtask

   task automatic t_alert;
      logic [7:0] rx;
      logic       ak, k;
      int         n;
      pulse_fault();
      `CHK("alert_set", 1'b1, alert_oe)
      smbus_mode = 1'b0;
      host.start();
      host.xfer(8'h19, 1'b1, rx, ak);
      host.stop();
      `CHK("ara_plain", 1'b1, ak)
      smbus_mode = 1'b1;
      host.start();
      host.xfer(8'h19, 1'b1, rx, ak);
      host.xfer(8'hFF, 1'b1, rx, k);
      host.stop();
      `CHK("ara_ack", 1'b0, ak)
      `CHK("ara_addr", {own7, 1'b0}, rx)
      `CHK("ara_release", 1'b0, alert_oe)
      pulse_fault();
      n = clr_cnt;
      send(own7, 8'h03, 1'b0, 8'h00, ak);
      `CHK("clear_pulse", n + 1, clr_cnt)
      `CHK("clear_alert", 1'b0, alert_oe)
      $display("alert test done");
   endtask

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      strap_valid = 1'b1;
      smbus_mode = 1'b1;
      fault_event = 1'b0;
      strap_code = 5'h00;
      t_strap();
      t_foreign();
      t_page();
      t_read();
      t_alert();
      complete_run();
   end
endmodule

// file: verilog/pmt_line_sync.sv
/*
 pmt_line_sync: three-stage synchroniser and glitch filter for the clock
 and data pins, with edge, start and stop detection. Assumes pins idle
 high through pull-ups and change far slower than the reference clock.
*/
`timescale 1ns/1ps
module pmt_line_sync (
   // clock and reset
   input  wire logic REF_CLK,
   input  wire logic NRST,
   input  wire logic CE,
   // raw pins
   input  wire logic SCL_I,
   input  wire logic SDA_I,
   // conditioned events
   pmt_line_if.src   ln
);
   pmt_pkg::pmt_sync_t q;
   pmt_pkg::pmt_sync_t d;
   logic [1:0]         agree;

   always_comb begin
      d = q;
      agree = ~(q.s2 ^ q.s3);
      d.s1 = {SCL_I, SDA_I};
      d.s2 = q.s1;
      d.s3 = q.s2;
      // a level counts only once the second and third stage agree
      d.filt = (q.s2 & agree) | (q.filt & ~agree);
      d.rise = ~q.filt[1] & d.filt[1];
      d.fall = q.filt[1] & ~d.filt[1];
      d.start = q.filt[1] & d.filt[1] & q.filt[0] & ~d.filt[0];
      d.stop = q.filt[1] & d.filt[1] & ~q.filt[0] & d.filt[0];
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         q <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, filt: 2'h3, default: 1'b0};
      end else if (CE) begin
         q <= d;
      end
   end

   assign ln.rise  = q.rise;
   assign ln.fall  = q.fall;
   assign ln.start = q.start;
   assign ln.stop  = q.stop;
   assign ln.sda   = q.filt[0];
endmodule

// file: verilog/pmt_target_port.sv
/*
 pmt_target_port: two-wire management target port of a dual rail power
 controller: strapped address, command framing, page selection, alert
 response. Assumes a host drives the bus clock and a register back end
 answers reads combinationally on the reference clock.
*/
// What this block does
// - target address comes from the strap code detected on the address pin
// - address byte low bit: 0 means write, 1 means read
// - strap addresses limited to 0x40-0x47 and 0x50-0x67
// - command byte decoded over the whole range 0x00 to 0xFF
// - page 0 steers paged commands to rail 0, page 1 to rail 1
// - framing follows power management bus 1.3 and system bus 2.0
// - read byte and word return data of the rail the page selects
// - alert response address answered in system bus mode, not plain I2C
// - port works with bus clocks from 50 kHz up to 2 MHz
// - page command selects rail 0, rail 1 or both; resets to 0
// - clear faults command clears all fault bits and releases alert
`timescale 1ns/1ps
`include "pmt_cfg.svh"
module pmt_target_port #(
   parameter int HOLD_CYC     = `PMT_SDA_HOLD_CYC,
   parameter int SCL_HALF_CYC = `PMT_SCL_HALF_CYC
) (
   // clock and reset
   input  wire logic       REF_CLK,
   input  wire logic       NRST,
   input  wire logic       CE,
   // bus pins
   input  wire logic       SCL_I,
   input  wire logic       SDA_I,
   output wire logic       SDA_O,
   output wire logic       SDA_OE,
   output wire logic       ALERT_O,
   output wire logic       ALERT_OE,
   // strap and mode
   input  wire logic [4:0] STRAP_CODE,
   input  wire logic       STRAP_VALID,
   input  wire logic       SMBUS_MODE,
   // fault side
   input  wire logic       FAULT_EVENT,
   output wire logic       CLEAR_FAULTS,
   // command side
   output wire logic [7:0] CMD_CODE,
   output wire logic       CMD_STROBE,
   output wire logic [7:0] WR_DATA,
   output wire logic       WR_STROBE,
   output wire logic [7:0] WR_INDEX,
   output wire logic       RD_REQ,
   output wire logic [7:0] RD_INDEX,
   input  wire logic [7:0] RD_DATA,
   // rail and status
   output wire logic [7:0] PAGE,
   output wire logic [1:0] RAIL_SEL,
   output wire logic [6:0] OWN_ADDR,
   output wire logic       ADDR_READY,
   output wire logic       BUSY
);
   localparam logic [7:0] HOLD8 = 8'(HOLD_CYC);

   if (HOLD_CYC < 1 || HOLD_CYC > 255 ||
       HOLD_CYC + `PMT_SYNC_LAT_CYC >= SCL_HALF_CYC) begin : g_chk
      $error("pmt_target_port: hold count does not fit the bus clock");
   end

   pmt_line_if         ln ();
   pmt_pkg::pmt_core_t q;
   pmt_pkg::pmt_core_t c;
   logic               rd_take;
   logic               clr_alert;
   logic [7:0]         b;
   logic               hit_own;
   logic               hit_ara;

   pmt_line_sync u_sync (
      .REF_CLK (REF_CLK),
      .NRST    (NRST),
      .CE      (CE),
      .SCL_I   (SCL_I),
      .SDA_I   (SDA_I),
      .ln      (ln)
   );

   function automatic logic [6:0] strap_addr(input logic [4:0] code);
      if (code < `PMT_ADDR_LO_COUNT) begin
         return `PMT_ADDR_LO_BASE + {2'b00, code};
      end
      return `PMT_ADDR_HI_BASE + {2'b00, code - `PMT_ADDR_LO_COUNT};
   endfunction

   function automatic logic [1:0] rail_of(input logic [7:0] pg);
      return {pg == `PMT_PAGE_RAIL1 || pg == `PMT_PAGE_BOTH,
              pg == `PMT_PAGE_RAIL0 || pg == `PMT_PAGE_BOTH};
   endfunction

   // page reads are local; the alert read gives our address, then idle
   function automatic logic [7:0] read_byte(input logic       ara,
                                            input logic       first,
                                            input logic       ok,
                                            input logic [7:0] cmd,
                                            input logic [7:0] pg,
                                            input logic [7:0] data,
                                            input logic [6:0] addr);
      if (ara) begin
         return first ? {addr, 1'b0} : `PMT_IDLE_BYTE;
      end
      if (!ok) begin
         return `PMT_IDLE_BYTE;
      end
      return (cmd == `PMT_CMD_PAGE) ? pg : data;
   endfunction

   always_comb begin
      c = q;
      c.cmd_stb = 1'b0;
      c.wr_stb = 1'b0;
      c.clr = 1'b0;
      rd_take = 1'b0;
      clr_alert = 1'b0;
      b = `PMT_IDLE_BYTE;
      // only a matching target ever drives
      // alert address only in system bus mode
      hit_ara = SMBUS_MODE && q.alert && q.sh == {`PMT_ARA_ADDR7, 1'b1};
      hit_own = q.addr_ok && q.sh[7:1] == q.addr7;
      // data changes only after the hold time past the clock fall
      if (q.hold != 8'h00) begin
         c.hold = q.hold - 8'h01;
         if (q.hold == 8'h01) begin
            c.oe = q.pend;
         end
      end
      if (!q.addr_ok && STRAP_VALID) begin
         c.addr7 = strap_addr(STRAP_CODE);
         c.addr_ok = 1'b1;
      end
      // command kept across repeated start, dropped at stop
      if (ln.stop) begin
         c.st = pmt_pkg::ST_IDLE;
         c.cmd_ok = 1'b0;
         c.oe = 1'b0;
         c.hold = 8'h00;
      end else if (ln.start) begin
         c.st = pmt_pkg::ST_ADDR;
         c.bitc = 4'h0;
         c.oe = 1'b0;
         c.hold = 8'h00;
      end else if (ln.rise) begin
         case (q.st)
            pmt_pkg::ST_ADDR, pmt_pkg::ST_CMD, pmt_pkg::ST_WDATA: begin
               c.sh = {q.sh[6:0], ln.sda};
               c.bitc = q.bitc + 4'h1;
            end
            pmt_pkg::ST_RDATA: begin
               c.sh = {q.sh[6:0], 1'b1};
               c.bitc = q.bitc + 4'h1;
            end
            pmt_pkg::ST_MACK: begin
               c.st = ln.sda ? pmt_pkg::ST_IGNORE : pmt_pkg::ST_RLOAD;
               c.idx = q.idx + 8'h01;
            end
            default: begin
            end
         endcase
      end else if (ln.fall) begin
         case (q.st)
            pmt_pkg::ST_ADDR: begin
               if (q.bitc == 4'h8) begin
                  if (hit_own || hit_ara) begin
                     c.st = pmt_pkg::ST_ADDR_ACK;
                     c.rw = (q.sh[0] == `PMT_RW_READ);
                     c.ara = hit_ara && !hit_own;
                     c.idx = 8'h00;
                     c.pend = 1'b1;
                     c.hold = HOLD8;
                  end else begin
                     c.st = pmt_pkg::ST_IGNORE;
                  end
               end
            end
            pmt_pkg::ST_ADDR_ACK, pmt_pkg::ST_RLOAD: begin
               c.bitc = 4'h0;
               if (q.rw) begin
                  // back end answers for the paged rail
                  b = read_byte(q.ara, q.st == pmt_pkg::ST_ADDR_ACK,
                                q.cmd_ok, q.cmd, q.page, RD_DATA, q.addr7);
                  rd_take = !q.ara && q.cmd_ok && q.cmd != `PMT_CMD_PAGE;
                  clr_alert = q.ara && q.st == pmt_pkg::ST_ADDR_ACK;
                  c.sh = b;
                  c.st = pmt_pkg::ST_RDATA;
                  c.pend = ~b[7];
               end else begin
                  c.st = pmt_pkg::ST_CMD;
                  c.pend = 1'b0;
               end
               c.hold = HOLD8;
            end
            pmt_pkg::ST_CMD: begin
               if (q.bitc == 4'h8) begin
                  c.cmd = q.sh;
                  c.cmd_ok = 1'b1;
                  c.cmd_stb = 1'b1;
                  if (q.sh == `PMT_CMD_CLEAR_FAULTS) begin
                     c.clr = 1'b1;
                     clr_alert = 1'b1;
                  end
                  c.st = pmt_pkg::ST_CMD_ACK;
                  c.pend = 1'b1;
                  c.hold = HOLD8;
               end
            end
            pmt_pkg::ST_WDATA: begin
               if (q.bitc == 4'h8) begin
                  c.wr_stb = 1'b1;
                  // page accepts rail 0, rail 1 or both
                  if (q.cmd == `PMT_CMD_PAGE && q.idx == 8'h00 &&
                      (q.sh == `PMT_PAGE_RAIL0 || q.sh == `PMT_PAGE_RAIL1 ||
                       q.sh == `PMT_PAGE_BOTH)) begin
                     c.page = q.sh;
                  end
                  c.st = pmt_pkg::ST_WACK;
                  c.pend = 1'b1;
                  c.hold = HOLD8;
               end
            end
            pmt_pkg::ST_CMD_ACK, pmt_pkg::ST_WACK: begin
               if (q.st == pmt_pkg::ST_WACK) begin
                  c.idx = q.idx + 8'h01;
               end
               c.st = pmt_pkg::ST_WDATA;
               c.bitc = 4'h0;
               c.pend = 1'b0;
               c.hold = HOLD8;
            end
            pmt_pkg::ST_RDATA: begin
               // release for the host's ack bit after the eighth bit
               c.pend = (q.bitc == 4'h8) ? 1'b0 : ~q.sh[7];
               c.hold = HOLD8;
               if (q.bitc == 4'h8) begin
                  c.st = pmt_pkg::ST_MACK;
               end
            end
            default: begin
            end
         endcase
      end
      // a new fault in the clearing cycle keeps the alert set
      c.alert = FAULT_EVENT | (q.alert & ~clr_alert);
      c.rail = rail_of(c.page);
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         q <= '{st: pmt_pkg::ST_IDLE, page: `PMT_PAGE_RESET,
                rail: 2'b01, default: '0};
      end else if (CE) begin
         q <= c;
      end
   end

   // open-drain signalling per the bus standards
   assign SDA_O      = 1'b0;
   assign SDA_OE     = q.oe;
   assign ALERT_O    = 1'b0;
   assign ALERT_OE   = q.alert;
   assign CLEAR_FAULTS = q.clr;
   assign CMD_CODE   = q.cmd;
   assign CMD_STROBE = q.cmd_stb;
   assign WR_DATA    = q.sh;
   assign WR_STROBE  = q.wr_stb;
   assign WR_INDEX   = q.idx;
   assign RD_REQ     = rd_take & CE;
   assign RD_INDEX   = q.idx;
   assign PAGE       = q.page;
   assign RAIL_SEL   = q.rail;
   assign OWN_ADDR   = q.addr7;
   assign ADDR_READY = q.addr_ok;
   assign BUSY       = (q.st != pmt_pkg::ST_IDLE);
endmodule
